// >>> rtl/bmps_top.sv
// Boot decision and default function select for the shared debug pins
`timescale 1ns/1ns
`default_nettype none
module bmps_top
	import bmps_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic tck_in,
	input wire logic port0_bit0_pin_in,
	input wire logic port0_bit1_pin_in,
	input wire logic port0_bit2_pin_in,
	input wire logic port0_bit3_pin_in,
	input wire logic [3:1] port0_data_in,
	input wire logic [3:1] port0_dir_in,
	input wire logic [31:0] boot_check_word_in,
	input wire logic boot_check_valid_in,
	output logic flash_read_req_out,
	output logic [FLASH_ADDR_W-1:0] flash_addr_out,
	output logic boot_done_out,
	output logic serial_download_out,
	output logic run_user_code_out,
	output logic debug_enable_out,
	output logic debug_reset_out,
	output logic return_test_clock_out,
	output logic port0_bit1_pin_out,
	output logic port0_bit1_pin_oe_out,
	output logic port0_bit2_pin_out,
	output logic port0_bit2_pin_oe_out,
	output logic port0_bit3_pin_out,
	output logic port0_bit3_pin_oe_out,
	output logic [3:0] port0_pin_value_out
);
	logic [3:0] pin_raw; // Port 0 pins as they arrive
	logic [3:0] pin_sync; // Port 0 pins after the synchroniser
	logic test_reset_n_sync; // Bit 0 read as the test reset level
	logic [LNK_W-1:0] link_raw; // Link-domain flops, seen raw
	logic [LNK_W-1:0] link_sync; // Same after crossing
	logic link_rise_tog; // Link rising-edge toggle
	logic link_fall_tog; // Link falling-edge toggle
	logic link_tdo; // Link data out

	// Boot decision state
	bmps_boot_state_t state_r;
	bmps_boot_state_t state_nxt;
	logic [2:0] settle_cnt_r; // Cycles since reset release
	logic [2:0] settle_cnt_nxt;
	logic strap_r; // Strap level caught once per reset
	logic strap_nxt;
	logic serial_dl_nxt;
	logic run_user_nxt;
	logic done_nxt;
	logic flash_req_nxt;
	logic [FLASH_ADDR_W-1:0] flash_addr_nxt;

	// Pin mux state
	logic jtag_sel; // Shared pins carry the debug functions
	logic b1_out_nxt;
	logic b1_oe_nxt;
	logic b2_out_nxt;
	logic b2_oe_nxt;
	logic b3_out_nxt;
	logic b3_oe_nxt;

	// Debug status state
	logic dbg_en_nxt;
	logic dbg_rst_nxt;
	logic return_test_clock_nxt;

	// All pin inputs pass the same three-stage filter
	assign pin_raw = {port0_bit3_pin_in, port0_bit2_pin_in, port0_bit1_pin_in,
		port0_bit0_pin_in};

	bmps_sync3 #(
		.WIDTH(4),
		.RST_VAL({3'h0, TEST_RST_SYNC_RST_VAL})
	) u_pin_sync (
		.clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.d_in(pin_raw),
		.q_out(pin_sync)
	);

	assign test_reset_n_sync = pin_sync[0];
	// Link logic runs on the test clock and is reset by the test reset pin.
	// Its reset is the raw pin, so a low test reset clears it even with
	// the test clock stopped.
	bmps_link u_link (
		.tck_in(tck_in),
		.test_reset_n_in(port0_bit0_pin_in),
		.tdi_in(port0_bit2_pin_in),
		.rise_tog_out(link_rise_tog),
		.fall_tog_out(link_fall_tog),
		.tdo_out(link_tdo)
	);
	assign link_raw[LNK_RISE] = link_rise_tog;
	assign link_raw[LNK_FALL] = link_fall_tog;
	assign link_raw[LNK_TDO] = link_tdo;
	// Link levels cross into the reference domain; each is a plain level
	bmps_sync3 #(
		.WIDTH(LNK_W),
		.RST_VAL('0)
	) u_link_sync (
		.clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.d_in(link_raw),
		.q_out(link_sync)
	);

	// Boot decision: wait for the filtered strap, then decide
	always_comb
	begin
		state_nxt = state_r;
		settle_cnt_nxt = settle_cnt_r;
		strap_nxt = strap_r;
		serial_dl_nxt = serial_download_out;
		run_user_nxt = run_user_code_out;
		done_nxt = boot_done_out;
		flash_req_nxt = flash_read_req_out;
		flash_addr_nxt = flash_addr_out;
		case (state_r)
			BST_SETTLE:
			begin
				// Let the strap pass the filter before trusting it
				if (settle_cnt_r != STRAP_SETTLE_CYC)
				begin
					settle_cnt_nxt = settle_cnt_r + 3'h1;
				end
				else
				begin
					strap_nxt = pin_sync[0];
					if (pin_sync[0])
					begin
						// High strap never looks at flash
						run_user_nxt = 1'b1;
						done_nxt = 1'b1;
						state_nxt = BST_DONE;
					end
					else
					begin
						flash_req_nxt = 1'b1;
						flash_addr_nxt = BOOT_CHECK_ADDR;
						state_nxt = BST_FLASH;
					end
				end
			end
			BST_FLASH:
			begin
				// Request stands until the word comes back
				if (boot_check_valid_in)
				begin
					flash_req_nxt = 1'b0;
					done_nxt = 1'b1;
					state_nxt = BST_DONE;
					if (boot_check_word_in == BOOT_ERASED_WORD)
					begin
						serial_dl_nxt = 1'b1;
					end
					else
					begin
						run_user_nxt = 1'b1;
					end
				end
			end
			BST_DONE:
			begin
				// Decision held until the next system reset
				state_nxt = BST_DONE;
			end
			default:
			begin
				state_nxt = BST_SETTLE;
			end
		endcase
	end

	// Boot decision registers
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r <= BST_SETTLE;
			settle_cnt_r <= 3'h0;
			strap_r <= STRAP_RST_VAL;
			serial_download_out <= 1'b0;
			run_user_code_out <= 1'b0;
			boot_done_out <= 1'b0;
			flash_read_req_out <= 1'b0;
			flash_addr_out <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			settle_cnt_r <= settle_cnt_nxt;
			strap_r <= strap_nxt;
			serial_download_out <= serial_dl_nxt;
			run_user_code_out <= run_user_nxt;
			boot_done_out <= done_nxt;
			flash_read_req_out <= flash_req_nxt;
			flash_addr_out <= flash_addr_nxt;
		end
	end

	// Debug functions only with a high strap and test reset released
	assign jtag_sel = boot_done_out && strap_r && test_reset_n_sync;

	// Pin mux: debug functions or the port's own data and direction.
	// Software must not touch bits 1 to 3 while a session runs; the mux
	// ignores them then, so a stray write cannot break the link.
	always_comb
	begin
		if (jtag_sel)
		begin
			b1_out_nxt = link_sync[LNK_TDO];
			b1_oe_nxt = 1'b1;
			b2_out_nxt = 1'b0;
			b2_oe_nxt = 1'b0;
			b3_out_nxt = 1'b0;
			b3_oe_nxt = 1'b0;
		end
		else
		begin
			// General-purpose; direction reset value makes these inputs
			b1_out_nxt = port0_data_in[P0_TDO_BIT];
			b1_oe_nxt = port0_dir_in[P0_TDO_BIT];
			b2_out_nxt = port0_data_in[P0_TDI_BIT];
			b2_oe_nxt = port0_dir_in[P0_TDI_BIT];
			b3_out_nxt = port0_data_in[P0_TCK_BIT];
			b3_oe_nxt = port0_dir_in[P0_TCK_BIT];
		end
	end

	// Pin mux registers; all pins released during reset
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			port0_bit1_pin_out <= 1'b0;
			port0_bit1_pin_oe_out <= 1'b0;
			port0_bit2_pin_out <= 1'b0;
			port0_bit2_pin_oe_out <= 1'b0;
			port0_bit3_pin_out <= 1'b0;
			port0_bit3_pin_oe_out <= 1'b0;
			port0_pin_value_out <= 4'h0;
		end
		else
		begin
			port0_bit1_pin_out <= b1_out_nxt;
			port0_bit1_pin_oe_out <= b1_oe_nxt;
			port0_bit2_pin_out <= b2_out_nxt;
			port0_bit2_pin_oe_out <= b2_oe_nxt;
			port0_bit3_pin_out <= b3_out_nxt;
			port0_bit3_pin_oe_out <= b3_oe_nxt;
			port0_pin_value_out <= pin_sync;
		end
	end

	// Return clock is the test clock rebuilt from both edge toggles; it lags
	// by the crossing, so an adaptive probe knows each edge has been seen
	always_comb
	begin
		dbg_en_nxt = jtag_sel;
		dbg_rst_nxt = !test_reset_n_sync;
		return_test_clock_nxt = link_sync[LNK_RISE] ^ link_sync[LNK_FALL];
	end

	// Debug status registers
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			debug_enable_out <= 1'b0;
			debug_reset_out <= 1'b1;
			return_test_clock_out <= 1'b0;
		end
		else
		begin
			debug_enable_out <= dbg_en_nxt;
			debug_reset_out <= dbg_rst_nxt;
			return_test_clock_out <= return_test_clock_nxt;
		end
	end

	// Checks on the reference domain
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// Erased word seen while waiting on flash
	sequence s_word_erased;
		state_r == BST_FLASH && boot_check_valid_in &&
			boot_check_word_in == BOOT_ERASED_WORD;
	endsequence
	// Programmed word seen while waiting on flash
	sequence s_word_programmed;
		state_r == BST_FLASH && boot_check_valid_in &&
			boot_check_word_in != BOOT_ERASED_WORD;
	endsequence
	a_erased_download: assert property (s_word_erased |=>
		serial_download_out && !run_user_code_out && boot_done_out)
		else $error("erased check word did not select download");
	a_programmed_run: assert property (s_word_programmed |=>
		run_user_code_out && !serial_download_out)
		else $error("programmed check word did not run user code");
	a_strap_high_run: assert property (
		state_r == BST_SETTLE && settle_cnt_r == STRAP_SETTLE_CYC && pin_sync[0]
		|=> run_user_code_out && !flash_read_req_out)
		else $error("high strap did not run user code at once");
	a_bit1_tdo: assert property (jtag_sel |=>
		port0_bit1_pin_oe_out && port0_bit1_pin_out == $past(link_sync[LNK_TDO]))
		else $error("bit 1 not driving data out in debug mode");
	a_bit2_gpio: assert property (!jtag_sel |=>
		port0_bit2_pin_oe_out == $past(port0_dir_in[P0_TDI_BIT]))
		else $error("bit 2 direction not from port when general-purpose");
	a_bit3_tck_in: assert property (jtag_sel |=> !port0_bit3_pin_oe_out)
		else $error("bit 3 driven while it is the test clock");
	a_trst_hold: assert property (!test_reset_n_sync |=> debug_reset_out &&
		!debug_enable_out && port0_bit1_pin_oe_out == $past(port0_dir_in[P0_TDO_BIT]))
		else $error("low test reset did not hold debug in reset");
	a_return_test_clock_follow: assert property (
		$changed(link_sync[LNK_RISE] ^ link_sync[LNK_FALL]) |=>
		return_test_clock_out == $past(link_sync[LNK_RISE] ^ link_sync[LNK_FALL]))
		else $error("return clock did not follow the test clock");
	a_strap_held: assert property (boot_done_out |=>
		$stable(strap_r) && boot_done_out && $stable(serial_download_out))
		else $error("boot decision changed before the next reset");
endmodule
`default_nettype wire

// >>> rtl/bmps_pkg.sv
// Shared constants and types for the boot-mode and debug pin select block
package bmps_pkg;
	// Flash word checked when the strap asks for download
	localparam int FLASH_ADDR_W = 24;
	localparam logic [FLASH_ADDR_W-1:0] BOOT_CHECK_ADDR = 24'h80_0014;
	// Erased flash reads as all ones
	localparam logic [31:0] BOOT_ERASED_WORD = 32'hFFFF_FFFF;
	// Cycles after reset release before the strap is trusted
	localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;
	// Strap level assumed until it is sampled
	localparam logic STRAP_RST_VAL = 1'b0;
	// Level a synchronised test reset shows during system reset
	localparam logic TEST_RST_SYNC_RST_VAL = 1'b0;
	// Positions of the shared pins inside the port 0 vectors
	localparam int P0_TDO_BIT = 1;
	localparam int P0_TDI_BIT = 2;
	localparam int P0_TCK_BIT = 3;
	// Index of each link signal in the crossed vector
	localparam int LNK_RISE = 0;
	localparam int LNK_FALL = 1;
	localparam int LNK_TDO = 2;
	localparam int LNK_W = 3;
	// Boot decision sequence
	typedef enum logic [1:0] {
		BST_SETTLE,
		BST_FLASH,
		BST_DONE
	} bmps_boot_state_t;
endpackage

// >>> rtl/bmps_sync3.sv
// Three-stage input synchroniser that updates once the last two stages agree
`timescale 1ns/1ns
`default_nettype none
module bmps_sync3
	import bmps_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	// Refuse a zero-width instance
	if (WIDTH < 1)
	begin : g_bad_width
		$error("bmps_sync3 needs WIDTH of at least one");
	end

	logic [WIDTH-1:0] s1_r; // First stage, read only by the second
	logic [WIDTH-1:0] s2_r; // Second stage
	logic [WIDTH-1:0] s3_r; // Third stage
	logic [WIDTH-1:0] q_nxt; // Accepted value

	// Each bit is accepted only where the two later stages agree
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_out[i];
		end
	end

	// Chain registers
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_out <= RST_VAL;
		end
		else
		begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_out <= q_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bmps_link.sv
// Debug-link logic clocked by the probe's test clock
`timescale 1ns/1ns
`default_nettype none
module bmps_link
	import bmps_pkg::*;
(
	input wire logic tck_in,
	input wire logic test_reset_n_in,
	input wire logic tdi_in,
	output logic rise_tog_out,
	output logic fall_tog_out,
	output logic tdo_out
);
	logic rise_tog_nxt; // Flips on every rising test clock edge
	logic bypass_r; // One-bit bypass path from data in
	logic bypass_nxt;
	logic fall_tog_nxt; // Flips on every falling test clock edge
	logic tdo_nxt;

	// Next values for both edges
	always_comb
	begin
		rise_tog_nxt = !rise_tog_out;
		bypass_nxt = tdi_in;
		fall_tog_nxt = !fall_tog_out;
		tdo_nxt = bypass_r;
	end

	// Data in is captured on the rising edge
	always_ff @(posedge tck_in or negedge test_reset_n_in)
	begin
		if (!test_reset_n_in)
		begin
			rise_tog_out <= 1'b0;
			bypass_r <= 1'b0;
		end
		else
		begin
			rise_tog_out <= rise_tog_nxt;
			bypass_r <= bypass_nxt;
		end
	end

	// Data out changes on the falling edge, as the probe expects
	always_ff @(negedge tck_in or negedge test_reset_n_in)
	begin
		if (!test_reset_n_in)
		begin
			fall_tog_out <= 1'b0;
			tdo_out <= 1'b0;
		end
		else
		begin
			fall_tog_out <= fall_tog_nxt;
			tdo_out <= tdo_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> sim/bmps_probe.sv
// Debug probe model driving the test clock and test data in adaptively
`timescale 1ns/1ns
`default_nettype none
module bmps_probe
(
	input wire logic return_test_clock_in,
	input wire logic start_in,
	input wire logic [7:0] tdi_bits_in,
	output logic tck_out,
	output logic tdi_out,
	output logic busy_out
);
	int i; // Bit position inside a frame
	// Idle state: clock parked low, data released to the pull-up level
	initial
	begin
		tck_out = 1'h0;
		tdi_out = 1'h1;
		busy_out = 1'h0;
	end
	// Eight-bit frame; each half period waits for the return clock,
	// so the crossing delay inside the device never loses an edge
	always @(posedge start_in)
	begin
		busy_out = 1'h1;
		for (i = 0; i < 8; i++)
		begin
			tdi_out = tdi_bits_in[i];
			#6 tck_out = 1'h1;
			wait (return_test_clock_in === 1'h1);
			#6 tck_out = 1'h0;
			wait (return_test_clock_in === 1'h0);
		end
		// Released data line falls back to the pull-up
		#6 tdi_out = 1'h1;
		busy_out = 1'h0;
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for boot decision, pin defaults and the debug link
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import bmps_pkg::*;
;
	logic ref_clk_in = 1'h0; // 4 ns system clock
	logic resetn_in = 1'h0; // System reset, held from time zero
	logic strap_r = 1'h0; // Board strap and test reset level
	logic [3:1] data_r = 3'h0; // Port data bits
	logic [3:1] dir_r = 3'h0; // Port direction bits
	logic [31:0] word_r = 32'h0000_0000; // Flash word answered
	logic valid_r = 1'h0; // Flash word qualifier
	logic start_r = 1'h0; // Starts one probe frame
	logic [7:0] bits_r = 8'h00; // Frame data for the probe
	wire logic tck_w, tdi_w, busy_w;
	logic req, done, serial, run, dbg_en, dbg_rst, return_test_clock;
	logic o1, e1, o2, e2, o3, e3;
	logic [FLASH_ADDR_W-1:0] addr;
	logic [3:0] pin_val;
	wire logic p1, p2, p3; // Resolved pin levels
	int miscompares = 0;
	int checked = 0;
	int return_test_clock_edges = 0; // Return clock rising edges seen
	// Undriven bit 1 floats to the weak pull-up; bits 2 and 3 take the probe's data in and test clock
	assign p1 = e1 ? o1 : 1'h1;
	assign p2 = e2 ? o2 : tdi_w;
	assign p3 = e3 ? o3 : tck_w;
	// Free-running system clock
	always #2 ref_clk_in = ~ref_clk_in;
	// Counts return clock edges for frame checks
	always @(posedge return_test_clock) return_test_clock_edges++;
	bmps_top dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .tck_in(p3),
		.port0_bit0_pin_in(strap_r), .port0_bit1_pin_in(p1), .port0_bit2_pin_in(p2),
		.port0_bit3_pin_in(p3), .port0_data_in(data_r), .port0_dir_in(dir_r),
		.boot_check_word_in(word_r), .boot_check_valid_in(valid_r),
		.flash_read_req_out(req), .flash_addr_out(addr), .boot_done_out(done),
		.serial_download_out(serial), .run_user_code_out(run),
		.debug_enable_out(dbg_en), .debug_reset_out(dbg_rst),
		.return_test_clock_out(return_test_clock), .port0_bit1_pin_out(o1), .port0_bit1_pin_oe_out(e1),
		.port0_bit2_pin_out(o2), .port0_bit2_pin_oe_out(e2), .port0_bit3_pin_out(o3),
		.port0_bit3_pin_oe_out(e3), .port0_pin_value_out(pin_val));
	bmps_probe probe_u (.return_test_clock_in(return_test_clock), .start_in(start_r), .tdi_bits_in(bits_r),
		.tck_out(tck_w), .tdi_out(tdi_w), .busy_out(busy_w));
	// Compare one value, counting and reporting mismatches
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// Ten-cycle reset with the strap set before release
	task boot(input logic strap);
		@(posedge ref_clk_in);
		resetn_in <= 1'h0;
		strap_r <= strap;
		valid_r <= 1'h0;
		repeat (10) @(posedge ref_clk_in);
		resetn_in <= 1'h1;
	endtask
	// Let n edges land, then sample settled outputs
	task settle(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// Low strap: early word ignored, then the answered word decides
	task sc_low(input logic [31:0] w, input logic dl);
		int k;
		@(posedge ref_clk_in);
		data_r <= 3'h5;
		dir_r <= 3'h3;
		boot(1'h0);
		@(posedge ref_clk_in);
		valid_r <= 1'h1;
		word_r <= BOOT_ERASED_WORD;
		@(posedge ref_clk_in);
		valid_r <= 1'h0;
		for (k = 0; k < 20 && req !== 1'h1; k++) settle(1);
		chk(req, 1'h1);
		chk(addr, BOOT_CHECK_ADDR);
		chk(done, 1'h0);
		@(posedge ref_clk_in);
		valid_r <= 1'h1;
		word_r <= w;
		@(posedge ref_clk_in);
		valid_r <= 1'h0;
		#1;
		chk({done, serial, run, req}, {1'h1, dl, ~dl, 1'h0});
		chk({e3, e2, e1}, 3'h3);
		chk({o3, o2, o1}, 3'h5);
		chk(dbg_en, 1'h0);
		// Strap moved after sampling must not change the decision, debug enable or the pin mux
		@(posedge ref_clk_in);
		strap_r <= 1'h1;
		settle(10);
		chk({serial, run, dbg_en, e1}, {dl, ~dl, 1'h0, 1'h1});
		chk(pin_val, 4'h3);
	endtask
	// One probe frame; bypass data must reach the data-out pin
	task frame(input logic [7:0] b);
		int k;
		@(posedge ref_clk_in);
		return_test_clock_edges = 0;
		bits_r <= b;
		start_r <= 1'h1;
		@(posedge ref_clk_in);
		start_r <= 1'h0;
		settle(2);
		// Port settings stay untouched while the session runs
		for (k = 0; k < 600 && busy_w === 1'h1; k++) settle(1);
		settle(10);
		chk(busy_w, 1'h0);
		chk(return_test_clock_edges, 8);
		chk(return_test_clock, 1'h0);
		chk(p1, b[7]);
	endtask
	// High strap: user code, debug functions on bits 1 to 3
	task sc_high;
		@(posedge ref_clk_in);
		data_r <= 3'h0;
		dir_r <= 3'h7;
		boot(1'h1);
		settle(12);
		chk({done, run, serial, req}, 4'hC);
		chk({e3, e2, e1}, 3'h1);
		chk({dbg_en, dbg_rst}, 2'h2);
		frame(8'h5A);
		frame(8'hA5);
	endtask
	// Test reset low forces general-purpose pins, release restores debug
	task sc_test_reset;
		@(posedge ref_clk_in);
		data_r <= 3'h6;
		strap_r <= 1'h0;
		settle(8);
		chk({dbg_rst, dbg_en}, 2'h2);
		chk({e3, e2, e1}, 3'h7);
		chk({o3, o2, o1}, 3'h6);
		chk(run, 1'h1);
		@(posedge ref_clk_in);
		strap_r <= 1'h1;
		settle(8);
		chk({dbg_rst, dbg_en, e1, e2}, 4'h6);
	endtask
	// Prints counts and the verdict, then stops
	task finish_test;
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		sc_low(BOOT_ERASED_WORD, 1'h1);
		sc_low(32'hFFFF_FFFE, 1'h0);
		sc_high;
		sc_test_reset;
		finish_test;
	end
	// Watchdog: the full run needs well under 10,000 cycles
	initial
	begin
		#40000;
		miscompares++;
		finish_test;
	end
endmodule
`default_nettype wire
